// ===== logic/cid_pkg.sv
// Constants and types for the compact instruction set opcode decoder.
// Assumes halfwords come from fetch on mclk; classes go to execute.
// How it works
// - Top six bits select the 16-bit space
// - Special-data opcode picks add, compare, copy, branches
// - Load/store only for classes 0101, 011x, 100x
// - Class 0101 sub-field orders register-offset operations
// - Immediate classes: 0xx store, 1xx load
// - Misc opcode gives stack adjust, extends, reversals
// - Push, pop, state change, breakpoint, hints; rest undefined
// - Hint with non-zero low field is undefined
// - Hint values zero to four name five hints
// - Unallocated hints act as no-operation, not undefined
// - 1101 space: branch, permanent undefined, supervisor call
// - Prefix 111 with non-zero length field means 32-bit
// - Length x1 undefined; 10 needs second top bit
// - Control space: special moves, misc, undefined, link branch
// - Misc control gives three barriers, rest undefined
`default_nettype none

package cid_pkg;

  // Halfword width
  localparam int CID_HW = 16;

  // 16-bit field positions
  localparam int CID_TOP_HI = 15;
  localparam int CID_TOP_LO = 10;
  localparam int CID_SPC_HI = 9;
  localparam int CID_SPC_LO = 6;
  localparam int CID_CLS_HI = 15;
  localparam int CID_CLS_LO = 12;
  localparam int CID_SUB_HI = 11;
  localparam int CID_SUB_LO = 9;
  localparam int CID_MSC_HI = 11;
  localparam int CID_MSC_LO = 5;
  localparam int CID_HNA_HI = 7;
  localparam int CID_HNA_LO = 4;
  localparam int CID_HNB_HI = 3;
  localparam int CID_HNB_LO = 0;
  localparam int CID_CND_HI = 11;
  localparam int CID_CND_LO = 8;

  // 32-bit field positions
  localparam int CID_PFX_HI = 15;
  localparam int CID_PFX_LO = 13;
  localparam int CID_LEN_HI = 12;
  localparam int CID_LEN_LO = 11;
  localparam int CID_SEC_TOP = 15;
  localparam int CID_BO1_HI = 10;
  localparam int CID_BO1_LO = 4;
  localparam int CID_BO2_HI = 14;
  localparam int CID_BO2_LO = 12;
  localparam int CID_MCO_HI = 7;
  localparam int CID_MCO_LO = 4;

  // Decoded instruction classes
  typedef enum logic [5:0] {
    CID_NONE, CID_OTHER_16, CID_ADD_REG, CID_UNPREDICTABLE,
    CID_REGISTER_COMPARE, CID_REGISTER_COPY, CID_BRANCH_EXCHANGE,
    CID_BRANCH_LINK_EXCHANGE, CID_WORD_STORE, CID_HALFWORD_STORE,
    CID_BYTE_STORE, CID_SIGNED_BYTE_LOAD, CID_WORD_LOAD,
    CID_HALFWORD_LOAD, CID_BYTE_LOAD, CID_SIGNED_HALFWORD_LOAD,
    CID_STACK_WORD_STORE, CID_STACK_WORD_LOAD, CID_STACK_ADD_IMM,
    CID_STACK_SUB_IMM, CID_SIGNED_HALF_EXTEND, CID_SIGNED_BYTE_EXTEND,
    CID_UNSIGNED_HALF_EXTEND, CID_UNSIGNED_BYTE_EXTEND,
    CID_PUSH_MULTIPLE, CID_POP_MULTIPLE, CID_CHANGE_PROCESSOR_STATE,
    CID_WORD_BYTE_REVERSAL, CID_PACKED_HALF_BYTE_REVERSAL,
    CID_SIGNED_HALF_BYTE_REVERSAL, CID_BREAKPOINT_INSTR,
    CID_NO_OPERATION, CID_YIELD, CID_WAIT_FOR_EVENT,
    CID_WAIT_FOR_INTERRUPT, CID_SEND_EVENT, CID_COND_BRANCH,
    CID_PERMANENT_UNDEFINED, CID_SUPERVISOR_CALL, CID_MOVE_TO_SPECIAL,
    CID_MOVE_FROM_SPECIAL, CID_DATA_SYNC_BARRIER,
    CID_DATA_MEMORY_BARRIER, CID_INSTRUCTION_SYNC_BARRIER,
    CID_BRANCH_WITH_LINK, CID_UNDEFINED
  } cid_class_t;

  // Reset values of the outputs
  localparam cid_class_t CID_CLASS_RST = CID_NONE;
  localparam logic CID_FLAG_RST = 1'b0;

endpackage : cid_pkg

`default_nettype wire

// ===== logic/cid_decoder.sv
// Registered opcode classifier for the compact 16/32-bit instruction set.
// Fetch gives both halfwords on mclk; execute reads results a cycle later.
`timescale 1ns/1ps
`default_nettype none

module cid_decoder (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // From fetch
  input  wire logic                     fetch_valid,
  input  wire logic [cid_pkg::CID_HW-1:0] instr_hi,
  input  wire logic [cid_pkg::CID_HW-1:0] instr_lo,
  // To execute
  output logic                          dec_valid_q,
  output cid_pkg::cid_class_t           dec_class_q,
  output logic                          dec_wide_q,
  output logic                          dec_undef_q,
  output logic                          dec_unpred_q
);
  import cid_pkg::*;

  cid_class_t  class_d;
  logic        wide_d;
  logic        undef_d;
  logic        unpred_d;
  logic [5:0]  top6;
  logic [3:0]  spc_op;
  logic [3:0]  ls_cls;
  logic [2:0]  ls_sub;
  logic [6:0]  misc_op;
  logic [3:0]  hint_a;
  logic [3:0]  hint_b;
  logic [3:0]  cnd_op;
  logic [1:0]  len_f;
  logic [6:0]  bo1;
  logic [2:0]  bo2;
  logic [3:0]  mc_op;

  // Field extraction
  assign top6    = instr_hi[CID_TOP_HI:CID_TOP_LO];
  assign spc_op  = instr_hi[CID_SPC_HI:CID_SPC_LO];
  assign ls_cls  = instr_hi[CID_CLS_HI:CID_CLS_LO];
  assign ls_sub  = instr_hi[CID_SUB_HI:CID_SUB_LO];
  assign misc_op = instr_hi[CID_MSC_HI:CID_MSC_LO];
  assign hint_a  = instr_hi[CID_HNA_HI:CID_HNA_LO];
  assign hint_b  = instr_hi[CID_HNB_HI:CID_HNB_LO];
  assign cnd_op  = instr_hi[CID_CND_HI:CID_CND_LO];
  assign len_f   = instr_hi[CID_LEN_HI:CID_LEN_LO];
  assign bo1     = instr_hi[CID_BO1_HI:CID_BO1_LO];
  assign bo2     = instr_lo[CID_BO2_HI:CID_BO2_LO];
  assign mc_op   = instr_lo[CID_MCO_HI:CID_MCO_LO];

  // Length detection
  always_comb begin
    wide_d = (instr_hi[CID_PFX_HI:CID_PFX_LO] == 3'b111)
             && (len_f != 2'b00);
  end

  // Class decode; undefined flag rides with the class
  always_comb begin
    class_d  = CID_NONE;
    undef_d  = 1'b0;
    unpred_d = 1'b0;
    if (!fetch_valid) begin
      class_d = CID_NONE;
    end else if (wide_d) begin
      if (len_f[0]) begin
        class_d = CID_UNDEFINED;
      end else if (!instr_lo[CID_SEC_TOP]) begin
        class_d = CID_UNDEFINED;
      end else if (bo2 == 3'b010 && bo1 == 7'b1111111) begin
        class_d = CID_PERMANENT_UNDEFINED;
      end else if (bo2[2] == 1'b0 && bo2[0] == 1'b0) begin
        casez (bo1)
          7'b011100? : class_d = CID_MOVE_TO_SPECIAL;
          7'b011111? : class_d = CID_MOVE_FROM_SPECIAL;
          7'b0111011 : begin
            unique case (mc_op)
              4'b0100 : class_d = CID_DATA_SYNC_BARRIER;
              4'b0101 : class_d = CID_DATA_MEMORY_BARRIER;
              4'b0110 : class_d = CID_INSTRUCTION_SYNC_BARRIER;
              default : class_d = CID_UNDEFINED;
            endcase
          end
          default    : class_d = CID_UNDEFINED;
        endcase
      end else if (bo2[2] && bo2[0]) begin
        class_d = CID_BRANCH_WITH_LINK;
      end else begin
        class_d = CID_UNDEFINED;
      end
    end else if (top6 == 6'b010001) begin
      // Special data and register branch space
      casez (spc_op)
        4'b00?? : class_d = CID_ADD_REG;
        4'b0100 : class_d = CID_UNPREDICTABLE;
        4'b0101 : class_d = CID_REGISTER_COMPARE;
        4'b10?? : class_d = CID_REGISTER_COPY;
        4'b110? : class_d = CID_BRANCH_EXCHANGE;
        4'b111? : class_d = CID_BRANCH_LINK_EXCHANGE;
        default : class_d = CID_UNDEFINED;
      endcase
    end else if (ls_cls == 4'b0101) begin
      // Register offset load/store
      unique case (ls_sub)
        3'b000 : class_d = CID_WORD_STORE;
        3'b001 : class_d = CID_HALFWORD_STORE;
        3'b010 : class_d = CID_BYTE_STORE;
        3'b011 : class_d = CID_SIGNED_BYTE_LOAD;
        3'b100 : class_d = CID_WORD_LOAD;
        3'b101 : class_d = CID_HALFWORD_LOAD;
        3'b110 : class_d = CID_BYTE_LOAD;
        3'b111 : class_d = CID_SIGNED_HALFWORD_LOAD;
      endcase
    end else if (ls_cls == 4'b0110) begin
      class_d = ls_sub[2] ? CID_WORD_LOAD : CID_WORD_STORE;
    end else if (ls_cls == 4'b0111) begin
      class_d = ls_sub[2] ? CID_BYTE_LOAD : CID_BYTE_STORE;
    end else if (ls_cls == 4'b1000) begin
      class_d = ls_sub[2] ? CID_HALFWORD_LOAD : CID_HALFWORD_STORE;
    end else if (ls_cls == 4'b1001) begin
      class_d = ls_sub[2] ? CID_STACK_WORD_LOAD : CID_STACK_WORD_STORE;
    end else if (top6[5:2] == 4'b1011) begin
      // Miscellaneous space
      casez (misc_op)
        7'b00000?? : class_d = CID_STACK_ADD_IMM;
        7'b00001?? : class_d = CID_STACK_SUB_IMM;
        7'b001000? : class_d = CID_SIGNED_HALF_EXTEND;
        7'b001001? : class_d = CID_SIGNED_BYTE_EXTEND;
        7'b001010? : class_d = CID_UNSIGNED_HALF_EXTEND;
        7'b001011? : class_d = CID_UNSIGNED_BYTE_EXTEND;
        7'b010???? : class_d = CID_PUSH_MULTIPLE;
        7'b0110011 : class_d = CID_CHANGE_PROCESSOR_STATE;
        7'b101000? : class_d = CID_WORD_BYTE_REVERSAL;
        7'b101001? : class_d = CID_PACKED_HALF_BYTE_REVERSAL;
        7'b101011? : class_d = CID_SIGNED_HALF_BYTE_REVERSAL;
        7'b110???? : class_d = CID_POP_MULTIPLE;
        7'b1110??? : class_d = CID_BREAKPOINT_INSTR;
        7'b1111??? : begin
          if (hint_b != 4'b0000) begin
            class_d = CID_UNDEFINED;
          end else begin
            unique case (hint_a)
              4'b0000 : class_d = CID_NO_OPERATION;
              4'b0001 : class_d = CID_YIELD;
              4'b0010 : class_d = CID_WAIT_FOR_EVENT;
              4'b0011 : class_d = CID_WAIT_FOR_INTERRUPT;
              4'b0100 : class_d = CID_SEND_EVENT;
              // Spare hints run as no-operation; software must avoid them
              default : class_d = CID_NO_OPERATION;
            endcase
          end
        end
        default    : class_d = CID_UNDEFINED;
      endcase
    end else if (top6[5:2] == 4'b1101) begin
      // Conditional branch and supervisor call
      unique case (cnd_op)
        4'b1110 : class_d = CID_PERMANENT_UNDEFINED;
        4'b1111 : class_d = CID_SUPERVISOR_CALL;
        default : class_d = CID_COND_BRANCH;
      endcase
    end else begin
      class_d = CID_OTHER_16;
    end
    undef_d = (class_d == CID_UNDEFINED)
              || (class_d == CID_PERMANENT_UNDEFINED);
    unpred_d = (class_d == CID_UNPREDICTABLE);
  end

  // Output register
  always_ff @(posedge mclk) begin
    if (rst) begin
      dec_valid_q  <= CID_FLAG_RST;
      dec_class_q  <= CID_CLASS_RST;
      dec_wide_q   <= CID_FLAG_RST;
      dec_undef_q  <= CID_FLAG_RST;
      dec_unpred_q <= CID_FLAG_RST;
    end else begin
      dec_valid_q  <= fetch_valid;
      dec_class_q  <= class_d;
      dec_wide_q   <= fetch_valid && wide_d;
      dec_undef_q  <= undef_d;
      dec_unpred_q <= unpred_d;
    end
  end

  // Copies of the inputs for the checks below
  logic [CID_HW-1:0] hi_q;
  logic [CID_HW-1:0] lo_q;
  always_ff @(posedge mclk) begin
    hi_q <= instr_hi;
    lo_q <= instr_lo;
  end

  // Checks
  property p_add_reg;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:8] == 8'b01000100 |->
      dec_class_q == CID_ADD_REG && !dec_undef_q;
  endproperty
  a_add_reg : assert property (p_add_reg)
    else $error("add register misdecoded");

  property p_reg_ldst;
    @(posedge mclk) disable iff (rst)
    fetch_valid && instr_hi[15:9] == 7'b0101011 |=>
      dec_class_q == CID_SIGNED_BYTE_LOAD;
  endproperty
  a_reg_ldst : assert property (p_reg_ldst)
    else $error("register offset load misdecoded");

  property p_imm_ldst;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:11] == 5'b10001 |->
      dec_class_q == CID_HALFWORD_LOAD;
  endproperty
  a_imm_ldst : assert property (p_imm_ldst)
    else $error("immediate halfword load misdecoded");

  property p_extend;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:6] == 10'b1011001001 |->
      dec_class_q == CID_SIGNED_BYTE_EXTEND;
  endproperty
  a_extend : assert property (p_extend)
    else $error("signed byte extend misdecoded");

  property p_push;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:9] == 7'b1011010 |->
      dec_class_q == CID_PUSH_MULTIPLE && !dec_undef_q;
  endproperty
  a_push : assert property (p_push)
    else $error("push misdecoded");

  property p_hint_undef;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:8] == 8'hBF && hi_q[3:0] != 4'h0 |->
      dec_undef_q && dec_class_q == CID_UNDEFINED;
  endproperty
  a_hint_undef : assert property (p_hint_undef)
    else $error("conditional block space not undefined");

  property p_wfi;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q == 16'hBF30 |-> dec_class_q == CID_WAIT_FOR_INTERRUPT;
  endproperty
  a_wfi : assert property (p_wfi)
    else $error("wait for interrupt misdecoded");

  property p_spare_hint;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:8] == 8'hBF && hi_q[3:0] == 4'h0
      && hi_q[7:4] > 4'h4 |->
      dec_class_q == CID_NO_OPERATION && !dec_undef_q;
  endproperty
  a_spare_hint : assert property (p_spare_hint)
    else $error("spare hint not a no-operation");

  property p_perm_undef;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:8] == 8'hDE |->
      dec_class_q == CID_PERMANENT_UNDEFINED && dec_undef_q;
  endproperty
  a_perm_undef : assert property (p_perm_undef)
    else $error("permanent undefined misdecoded");

  property p_wide;
    @(posedge mclk) disable iff (rst)
    dec_valid_q |->
      dec_wide_q == (hi_q[15:13] == 3'b111 && hi_q[12:11] != 2'b00);
  endproperty
  a_wide : assert property (p_wide)
    else $error("length detection wrong");

  property p_len_undef;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:13] == 3'b111 && hi_q[11] |-> dec_undef_q;
  endproperty
  a_len_undef : assert property (p_len_undef)
    else $error("length x1 not undefined");

  property p_link;
    @(posedge mclk) disable iff (rst)
    dec_valid_q && hi_q[15:11] == 5'b11110 && lo_q[15:14] == 2'b11
      && lo_q[12] |-> dec_class_q == CID_BRANCH_WITH_LINK;
  endproperty
  a_link : assert property (p_link)
    else $error("branch with link misdecoded");

  property p_barrier;
    @(posedge mclk) disable iff (rst)
    fetch_valid && instr_hi == 16'hF3BF && instr_lo[15:14] == 2'b10
      && instr_lo[12] == 1'b0 && instr_lo[7:4] == 4'h5 |=>
      dec_class_q == CID_DATA_MEMORY_BARRIER;
  endproperty
  a_barrier : assert property (p_barrier)
    else $error("memory barrier misdecoded");

  property p_flag_pairs;
    @(posedge mclk) disable iff (rst)
    fetch_valid ##1 !fetch_valid |-> dec_valid_q ##1 !dec_valid_q
      && dec_class_q == CID_NONE && !dec_undef_q;
  endproperty
  a_flag_pairs : assert property (p_flag_pairs)
    else $error("result does not follow fetch by one cycle");

  // Main scenarios
  c_wide_bl : cover property (@(posedge mclk) disable iff (rst)
    dec_class_q == CID_BRANCH_WITH_LINK);
  c_undef : cover property (@(posedge mclk) disable iff (rst)
    dec_valid_q && dec_undef_q);
  c_svc_after_ld : cover property (@(posedge mclk) disable iff (rst)
    dec_class_q == CID_WORD_LOAD ##1 dec_class_q == CID_SUPERVISOR_CALL);

endmodule : cid_decoder

`default_nettype wire

// ===== test/cid_fetch_model.sv
// Behavioural fetch stage that offers halfwords to the opcode decoder.
// Assumes the bench calls its tasks just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none

module cid_fetch_model (
  // Toward the decoder
  output logic                       fetch_valid,
  output logic [cid_pkg::CID_HW-1:0] instr_hi,
  output logic [cid_pkg::CID_HW-1:0] instr_lo
);
  import cid_pkg::*;

  // Nothing offered at time zero
  initial begin
    fetch_valid = 1'b0;
    instr_hi    = 16'h0000;
    instr_lo    = 16'hFFFF;
  end

  // Offer one instruction, both halfwords in the same cycle
  task automatic issue(input logic [CID_HW-1:0] hi, input logic [CID_HW-1:0] lo);
    fetch_valid = 1'b1;
    instr_hi    = hi;
    instr_lo    = lo;
  endtask : issue

  // Released lines show the inverse of the last value, not stale data
  task automatic idle();
    fetch_valid = 1'b0;
    instr_hi    = ~instr_hi;
    instr_lo    = ~instr_lo;
  endtask : idle
endmodule : cid_fetch_model

`default_nettype wire

// ===== test/test_compact_isa_opcode_decoder.sv
// Self-checking bench for the opcode decoder, one task per scenario.
// Assumes the fetch model drives inputs 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none

module test_compact_isa_opcode_decoder;
  import cid_pkg::*;

  logic        mclk;
  logic        rst;
  logic        fetch_valid;
  logic [15:0] instr_hi;
  logic [15:0] instr_lo;
  logic        dec_valid_q;
  cid_class_t  dec_class_q;
  logic        dec_wide_q;
  logic        dec_undef_q;
  logic        dec_unpred_q;
  int          mismatches;
  int          check_count;

  cid_fetch_model cid_fetch_model_inst (
    .fetch_valid (fetch_valid),
    .instr_hi    (instr_hi),
    .instr_lo    (instr_lo)
  );

  cid_decoder cid_decoder_inst (
    .mclk         (mclk),
    .rst          (rst),
    .fetch_valid  (fetch_valid),
    .instr_hi     (instr_hi),
    .instr_lo     (instr_lo),
    .dec_valid_q  (dec_valid_q),
    .dec_class_q  (dec_class_q),
    .dec_wide_q   (dec_wide_q),
    .dec_undef_q  (dec_undef_q),
    .dec_unpred_q (dec_unpred_q)
  );

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Compare one value and count it
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Outputs of an empty cycle
  task automatic check_empty();
    check("valid", 8'(dec_valid_q), 8'h00);
    check("class", 8'(dec_class_q), 8'(CID_NONE));
    check("wide", 8'(dec_wide_q), 8'h00);
    check("undef", 8'(dec_undef_q), 8'h00);
    check("unpred", 8'(dec_unpred_q), 8'h00);
  endtask : check_empty

  // Offer one instruction, judge it one cycle later; f = {wide, undef, unpred}
  task automatic d(input logic [15:0] hi, input logic [15:0] lo, input cid_class_t c,
                   input logic [2:0] f);
    cid_fetch_model_inst.issue(hi, lo);
    @(posedge mclk);
    #1;
    check("valid", 8'(dec_valid_q), 8'h01);
    check("class", 8'(dec_class_q), 8'(c));
    check("wide", 8'(dec_wide_q), {7'h00, f[2]});
    check("undef", 8'(dec_undef_q), {7'h00, f[1]});
    check("unpred", 8'(dec_unpred_q), {7'h00, f[0]});
  endtask : d

  // 16-bit form; second halfword carries junk
  task automatic s(input logic [15:0] hi, input cid_class_t c, input logic [2:0] f);
    d(hi, ~hi, c, f);
  endtask : s

  // Special data space, every opcode group
  task automatic t_special();
    s(16'h4400, CID_ADD_REG, 3'h0);
    s(16'h4500, CID_UNPREDICTABLE, 3'h1);
    s(16'h4540, CID_REGISTER_COMPARE, 3'h0);
    s(16'h4580, CID_UNDEFINED, 3'h2);
    s(16'h4600, CID_REGISTER_COPY, 3'h0);
    s(16'h4700, CID_BRANCH_EXCHANGE, 3'h0);
    s(16'h4780, CID_BRANCH_LINK_EXCHANGE, 3'h0);
    $display("test special done");
  endtask : t_special

  // Single item loads and stores, all sub-fields of class 0101
  task automatic t_ldst();
    s(16'h5000, CID_WORD_STORE, 3'h0);
    s(16'h5200, CID_HALFWORD_STORE, 3'h0);
    s(16'h5400, CID_BYTE_STORE, 3'h0);
    s(16'h5600, CID_SIGNED_BYTE_LOAD, 3'h0);
    s(16'h5800, CID_WORD_LOAD, 3'h0);
    s(16'h5A00, CID_HALFWORD_LOAD, 3'h0);
    s(16'h5C00, CID_BYTE_LOAD, 3'h0);
    s(16'h5E00, CID_SIGNED_HALFWORD_LOAD, 3'h0);
    s(16'h6600, CID_WORD_STORE, 3'h0);
    s(16'h6800, CID_WORD_LOAD, 3'h0);
    s(16'h7000, CID_BYTE_STORE, 3'h0);
    s(16'h7E00, CID_BYTE_LOAD, 3'h0);
    s(16'h8000, CID_HALFWORD_STORE, 3'h0);
    s(16'h8800, CID_HALFWORD_LOAD, 3'h0);
    s(16'h9600, CID_STACK_WORD_STORE, 3'h0);
    s(16'h9800, CID_STACK_WORD_LOAD, 3'h0);
    s(16'h4800, CID_OTHER_16, 3'h0);
    s(16'hA000, CID_OTHER_16, 3'h0);
    $display("test ldst done");
  endtask : t_ldst

  // Miscellaneous space including holes
  task automatic t_misc();
    s(16'hB000, CID_STACK_ADD_IMM, 3'h0);
    s(16'hB080, CID_STACK_SUB_IMM, 3'h0);
    s(16'hB200, CID_SIGNED_HALF_EXTEND, 3'h0);
    s(16'hB240, CID_SIGNED_BYTE_EXTEND, 3'h0);
    s(16'hB280, CID_UNSIGNED_HALF_EXTEND, 3'h0);
    s(16'hB2C0, CID_UNSIGNED_BYTE_EXTEND, 3'h0);
    s(16'hBA00, CID_WORD_BYTE_REVERSAL, 3'h0);
    s(16'hBA40, CID_PACKED_HALF_BYTE_REVERSAL, 3'h0);
    s(16'hBAC0, CID_SIGNED_HALF_BYTE_REVERSAL, 3'h0);
    s(16'hBA80, CID_UNDEFINED, 3'h2);
    s(16'hB5FF, CID_PUSH_MULTIPLE, 3'h0);
    s(16'hBD00, CID_POP_MULTIPLE, 3'h0);
    s(16'hB660, CID_CHANGE_PROCESSOR_STATE, 3'h0);
    s(16'hB640, CID_UNDEFINED, 3'h2);
    s(16'hB100, CID_UNDEFINED, 3'h2);
    s(16'hBE12, CID_BREAKPOINT_INSTR, 3'h0);
    $display("test misc done");
  endtask : t_misc

  // Hint space
  task automatic t_hint();
    s(16'hBF00, CID_NO_OPERATION, 3'h0);
    s(16'hBF10, CID_YIELD, 3'h0);
    s(16'hBF20, CID_WAIT_FOR_EVENT, 3'h0);
    s(16'hBF30, CID_WAIT_FOR_INTERRUPT, 3'h0);
    s(16'hBF40, CID_SEND_EVENT, 3'h0);
    s(16'hBF50, CID_NO_OPERATION, 3'h0);
    s(16'hBFF0, CID_NO_OPERATION, 3'h0);
    s(16'hBF01, CID_UNDEFINED, 3'h2);
    s(16'hBF38, CID_UNDEFINED, 3'h2);
    $display("test hint done");
  endtask : t_hint

  // Conditional branch space
  task automatic t_cond();
    s(16'hD000, CID_COND_BRANCH, 3'h0);
    s(16'hDD7F, CID_COND_BRANCH, 3'h0);
    s(16'hDE00, CID_PERMANENT_UNDEFINED, 3'h2);
    s(16'h6800, CID_WORD_LOAD, 3'h0);
    s(16'hDF05, CID_SUPERVISOR_CALL, 3'h0);
    $display("test cond done");
  endtask : t_cond

  // Length detection and 32-bit control space
  task automatic t_wide();
    s(16'hE000, CID_OTHER_16, 3'h0);
    d(16'hF000, 16'hF800, CID_BRANCH_WITH_LINK, 3'h4);
    d(16'hF7FF, 16'hD000, CID_BRANCH_WITH_LINK, 3'h4);
    d(16'hE800, 16'hF800, CID_UNDEFINED, 3'h6);
    d(16'hF800, 16'hF800, CID_UNDEFINED, 3'h6);
    d(16'hF000, 16'h7800, CID_UNDEFINED, 3'h6);
    d(16'hF380, 16'h8800, CID_MOVE_TO_SPECIAL, 3'h4);
    d(16'hF3EF, 16'h8000, CID_MOVE_FROM_SPECIAL, 3'h4);
    d(16'hF7F0, 16'hA000, CID_PERMANENT_UNDEFINED, 3'h6);
    d(16'hF000, 16'h8000, CID_UNDEFINED, 3'h6);
    d(16'hF000, 16'h9000, CID_UNDEFINED, 3'h6);
    d(16'hF3B0, 16'h8F40, CID_DATA_SYNC_BARRIER, 3'h4);
    d(16'hF3BF, 16'h8F5F, CID_DATA_MEMORY_BARRIER, 3'h4);
    d(16'hF3B0, 16'h8F60, CID_INSTRUCTION_SYNC_BARRIER, 3'h4);
    d(16'hF3B0, 16'h8F70, CID_UNDEFINED, 3'h6);
    $display("test wide done");
  endtask : t_wide

  // Empty cycle, then reset in mid-run with an instruction offered
  task automatic t_idle();
    cid_fetch_model_inst.idle();
    @(posedge mclk);
    #1;
    check_empty();
    cid_fetch_model_inst.issue(16'hBF30, 16'h0000);
    rst = 1'b1;
    @(posedge mclk);
    #1;
    check_empty();
    rst = 1'b0;
    s(16'hBF30, CID_WAIT_FOR_INTERRUPT, 3'h0);
    $display("test idle done");
  endtask : t_idle

  // Main sequence
  initial begin
    mismatches  = 0;
    check_count = 0;
    rst         = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    check_empty();
    t_special();
    t_ldst();
    t_misc();
    t_hint();
    t_cond();
    t_wide();
    t_idle();
    report_and_stop();
  end

  // Watchdog, far beyond the 81 cycles the tests need
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule : test_compact_isa_opcode_decoder

`default_nettype wire
